/* hw/stop_mode_peripheral_gating.sv */
// stop mode selection, peripheral and debug clock gating and per-module power gating with an axi4-lite slave
`timescale 1ns/100ps
`include "stop_gating_defs.svh"

// Contract
// - any stop halts all peripheral clocks except listed module exceptions.
// - debug enabled at stop keeps debug clock, still gates peripheral clocks.
// - shallow stop: converter on only with async clock and detector enabled.
// - shallow stop: comparator on; with bandgap select it needs the detector.
// - shallow stop: clock generator on only with both internal reference enables.
// - both stops: counter runs only if prescaler select was nonzero, else off.
// - shallow stop: oscillator on only with both external reference enables.
// - high range oscillator in shallow stop also needs the detector enabled.
// - shallow stop: usb on only with module and transceiver enables, else off.
// - detector enabled for stop keeps regulator on and forces shallow stop.
// - debug enabled turns a deep stop request into a shallow stop.
// - deep stop latches all pin control signals for its duration.
module stop_mode_peripheral_gating #(
   parameter int ADDR_W = 12
) (
   input  wire logic                          sys_clk,
   input  wire logic                          reset,
   input  wire logic                          stopReq,
   input  wire logic                          wakeReq,
   output logic                               illegalStop,
   output logic                               periphClkEn,
   output logic                               debugClkEn,
   output logic                               regulatorActive,
   output logic                               ioHold,
   output stop_gating_pkg::module_power_t     modulePower,
   input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [ADDR_W-1:0]             s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready
);

   if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 4 and 32");
   end

   // a literal cannot be part-selected, so the mask lives in a named constant
   localparam logic [31:0] CFG_WMASK = `SG_CFG_WMASK;

   stop_gating_pkg::cfg_t          cfg_reg;
   stop_gating_pkg::cfg_t          snap_reg;
   stop_gating_pkg::cfg_t          snap_next;
   stop_gating_pkg::stop_state_t   state_reg;
   stop_gating_pkg::stop_state_t   state_next;
   stop_gating_pkg::module_power_t power_next;
   logic                           stopEntry;
   logic                           detectorInStop;
   logic [33:0]                    powerBits;
   logic                           writeGo;

   assign detectorInStop = cfg_reg.lowVoltageDetectEnable & cfg_reg.lowVoltageStopEnable;
   assign stopEntry      = (state_reg == stop_gating_pkg::RUN) & stopReq
                           & cfg_reg.stopInstructionEnable;

   // mode choice at entry
   always_comb begin
      state_next = state_reg;
      snap_next  = snap_reg;
      if (stopEntry) begin
         snap_next = cfg_reg;
         if (cfg_reg.partialPowerdownControl && !cfg_reg.debugModeEnable
             && !detectorInStop) begin
            state_next = stop_gating_pkg::STOP2;
         end else begin
            state_next = stop_gating_pkg::STOP3;
         end
      end else if (state_reg != stop_gating_pkg::RUN && wakeReq) begin
         state_next = stop_gating_pkg::RUN;
      end
   end

   // power decision is taken from the snapshot, so config writes during stop do not disturb it
   function automatic stop_gating_pkg::module_power_t decide(
      input stop_gating_pkg::stop_state_t st,
      input stop_gating_pkg::cfg_t        c
   );
      stop_gating_pkg::module_power_t p;
      logic                           det;
      det = c.lowVoltageDetectEnable & c.lowVoltageStopEnable;
      p   = '{default: stop_gating_pkg::PWR_ON};
      if (st == stop_gating_pkg::STOP2) begin
         p        = '{default: stop_gating_pkg::PWR_OFF};
         p.ram    = stop_gating_pkg::PWR_STANDBY;
         p.usbRam = stop_gating_pkg::PWR_STANDBY;
      end else if (st == stop_gating_pkg::STOP3) begin
         p = '{default: stop_gating_pkg::PWR_STANDBY};
         if (c.converterAsyncClockEnable && det) begin
            p.converter = stop_gating_pkg::PWR_ON;
         end
         if (!c.comparatorBandgapSelect || det) begin
            p.analogComparator = stop_gating_pkg::PWR_ON;
         end
         if (c.internalRefClockEnable && c.internalRefStopEnable) begin
            p.clockGenerator = stop_gating_pkg::PWR_ON;
         end
         if (c.externalRefClockEnable && c.externalRefStopEnable
             && (!c.oscHighRange || det)) begin
            p.externalOscillator = stop_gating_pkg::PWR_ON;
         end
         p.usb = (c.usbModuleEnable && c.usbTransceiverEnable) ?
                 stop_gating_pkg::PWR_ON : stop_gating_pkg::PWR_OFF;
         if (det || c.debugModeEnable) begin
            p.regulator = stop_gating_pkg::PWR_ON;
         end
      end
      if (st != stop_gating_pkg::RUN) begin
         p.counter = (c.counterPrescalerSelect != `SG_PRESCALER_OFF) ?
                     stop_gating_pkg::PWR_ON : stop_gating_pkg::PWR_OFF;
      end
      return p;
   endfunction : decide

   assign power_next = decide(state_next, snap_next);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= stop_gating_pkg::RUN;
         snap_reg  <= `SG_CFG_RESET;
      end else begin
         state_reg <= state_next;
         snap_reg  <= snap_next;
      end
   end

   // outputs except illegalStop registered from next state so they move with the state
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         modulePower     <= '{default: stop_gating_pkg::PWR_ON};
         periphClkEn     <= 1'b1;
         debugClkEn      <= 1'b1;
         regulatorActive <= 1'b1;
         ioHold          <= 1'b0;
         illegalStop     <= 1'b0;
      end else begin
         modulePower     <= power_next;
         periphClkEn     <= (state_next == stop_gating_pkg::RUN);
         debugClkEn      <= (state_next == stop_gating_pkg::RUN)
                            | snap_next.debugModeEnable;
         regulatorActive <= (power_next.regulator == stop_gating_pkg::PWR_ON);
         ioHold          <= (state_next == stop_gating_pkg::STOP2);
         illegalStop     <= (state_reg == stop_gating_pkg::RUN) & stopReq
                            & ~cfg_reg.stopInstructionEnable;
      end
   end

   // write path: address and data taken together, master holds both until taken
   assign writeGo       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = writeGo;
   assign s_axi_wready  = writeGo;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cfg_reg <= `SG_CFG_RESET;
      end else if (writeGo && s_axi_awaddr == ADDR_W'(`SG_CFG_OFFSET)) begin
         for (int b = 0; b < 4; b++) begin
            if (s_axi_wstrb[b]) begin
               cfg_reg[b*8 +: 8] <= s_axi_wdata[b*8 +: 8] & CFG_WMASK[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SG_RESP_OKAY;
      end else if (writeGo) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (s_axi_awaddr == ADDR_W'(`SG_CFG_OFFSET)) ?
                         `SG_RESP_OKAY : `SG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign powerBits = modulePower;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `SG_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `SG_RESP_OKAY;
         if (s_axi_araddr == ADDR_W'(`SG_CFG_OFFSET)) begin
            s_axi_rdata <= cfg_reg;
         end else if (s_axi_araddr == ADDR_W'(`SG_STATUS_OFFSET)) begin
            s_axi_rdata <= {23'h000000, powerBits[33:32], ioHold, regulatorActive,
                            debugClkEn, periphClkEn, state_reg};
         end else if (s_axi_araddr == ADDR_W'(`SG_POWER_OFFSET)) begin
            s_axi_rdata <= powerBits[31:0];
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SG_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   sequence s_entry;
      (state_reg == stop_gating_pkg::RUN) && stopReq && cfg_reg.stopInstructionEnable;
   endsequence

   property p_clk_halt;
      @(posedge sys_clk) disable iff (reset)
      (state_reg != stop_gating_pkg::RUN) |-> !periphClkEn;
   endproperty
   a_clk_halt: assert property (p_clk_halt) else $error("peripheral clock runs in stop");

   property p_debug_clk;
      @(posedge sys_clk) disable iff (reset)
      (s_entry and cfg_reg.debugModeEnable) |=> debugClkEn && !periphClkEn;
   endproperty
   a_debug_clk: assert property (p_debug_clk) else $error("debug clock gating wrong");

   property p_converter;
      @(posedge sys_clk) disable iff (reset)
      (state_reg == stop_gating_pkg::STOP3) |->
      ((modulePower.converter == stop_gating_pkg::PWR_ON) ==
       (snap_reg.converterAsyncClockEnable && snap_reg.lowVoltageDetectEnable
        && snap_reg.lowVoltageStopEnable));
   endproperty
   a_converter: assert property (p_converter) else $error("converter state wrong");

   property p_counter;
      @(posedge sys_clk) disable iff (reset)
      (state_reg != stop_gating_pkg::RUN) |->
      ((modulePower.counter == stop_gating_pkg::PWR_OFF) ==
       (snap_reg.counterPrescalerSelect == `SG_PRESCALER_OFF));
   endproperty
   a_counter: assert property (p_counter) else $error("counter state wrong");

   property p_usb;
      @(posedge sys_clk) disable iff (reset)
      (state_reg == stop_gating_pkg::STOP3) |->
      ((modulePower.usb == stop_gating_pkg::PWR_ON) ==
       (snap_reg.usbModuleEnable && snap_reg.usbTransceiverEnable));
   endproperty
   a_usb: assert property (p_usb) else $error("usb left on");

   property p_deep_off;
      @(posedge sys_clk) disable iff (reset)
      (state_reg == stop_gating_pkg::STOP2) |->
      modulePower.cpu == stop_gating_pkg::PWR_OFF
      && modulePower.ram == stop_gating_pkg::PWR_STANDBY;
   endproperty
   a_deep_off: assert property (p_deep_off) else $error("deep stop power wrong");

   property p_detector_shallow;
      @(posedge sys_clk) disable iff (reset)
      (s_entry and cfg_reg.lowVoltageDetectEnable && cfg_reg.lowVoltageStopEnable)
      |=> (state_reg == stop_gating_pkg::STOP3) && regulatorActive;
   endproperty
   a_detector_shallow: assert property (p_detector_shallow) else $error("detector stop");

   property p_debug_shallow;
      @(posedge sys_clk) disable iff (reset)
      (s_entry and cfg_reg.debugModeEnable) |=> state_reg == stop_gating_pkg::STOP3;
   endproperty
   a_debug_shallow: assert property (p_debug_shallow) else $error("debug entered deep stop");

   property p_io_hold;
      @(posedge sys_clk) disable iff (reset)
      // a wake one cycle after entry is legal, so hold tracks the state itself
      ioHold == (state_reg == stop_gating_pkg::STOP2);
   endproperty
   a_io_hold: assert property (p_io_hold) else $error("pins not held in deep stop");

endmodule : stop_mode_peripheral_gating

/* hw/stop_gating_defs.svh */
// offsets, reset values and codes for the stop mode gating block
`ifndef STOP_GATING_DEFS_SVH
`define STOP_GATING_DEFS_SVH

`define SG_CFG_OFFSET     12'h000
`define SG_STATUS_OFFSET  12'h004
`define SG_POWER_OFFSET   12'h008
`define SG_CFG_RESET      32'h0000_0000
`define SG_CFG_WMASK      32'h0003_ffff
`define SG_RESP_OKAY      2'h0
`define SG_RESP_SLVERR    2'h2
`define SG_PRESCALER_OFF  4'h0

`endif

/* hw/stop_gating_pkg.sv */
// types for the stop mode gating block
package stop_gating_pkg;

   typedef enum logic [2:0] {
      RUN   = 3'h1,
      STOP3 = 3'h2,
      STOP2 = 3'h4
   } stop_state_t;

   typedef enum logic [1:0] {
      PWR_OFF     = 2'h0,
      PWR_STANDBY = 2'h1,
      PWR_ON      = 2'h2
   } power_t;

   // software configuration word, low bit first from the bottom
   typedef struct packed {
      logic [13:0] reserved;
      logic [3:0]  counterPrescalerSelect;
      logic        usbTransceiverEnable;
      logic        usbModuleEnable;
      logic        oscHighRange;
      logic        externalRefStopEnable;
      logic        externalRefClockEnable;
      logic        internalRefStopEnable;
      logic        internalRefClockEnable;
      logic        comparatorBandgapSelect;
      logic        converterAsyncClockEnable;
      logic        debugModeEnable;
      logic        lowVoltageStopEnable;
      logic        lowVoltageDetectEnable;
      logic        partialPowerdownControl;
      logic        stopInstructionEnable;
   } cfg_t;

   typedef struct packed {
      power_t cpu;
      power_t ram;
      power_t flash;
      power_t portRegs;
      power_t converter;
      power_t analogComparator;
      power_t clockGenerator;
      power_t iic;
      power_t counter;
      power_t sci;
      power_t spi;
      power_t tpm;
      power_t regulator;
      power_t externalOscillator;
      power_t usb;
      power_t usbRegulator;
      power_t usbRam;
   } module_power_t;

endpackage : stop_gating_pkg

/* verification/cpu_stop_model.sv */
// cpu core side: issues stop requests and wake events to the gating block
`timescale 1ns/100ps

module cpu_stop_model (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic stopCmd,
   input  wire logic wakeCmd,
   output logic      stopReq,
   output logic      wakeReq
);

   // registered, so requests always leave just after an edge like the real core
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stopReq <= 1'b0;
         wakeReq <= 1'b0;
      end else begin
         stopReq <= stopCmd;
         wakeReq <= wakeCmd;
      end
   end

endmodule : cpu_stop_model

/* verification/tb_top.sv */
// self-checking bench for the stop mode gating block
`timescale 1ns/100ps
`include "stop_gating_defs.svh"
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s exp=%h got=%h", nm, (e), (g)); end end

module tb_top;
   logic                           sys_clk = 1'b0;
   logic                           reset, stopCmd, wakeCmd, stopReq, wakeReq;
   logic                           illegalStop, periphClkEn, debugClkEn;
   logic                           regulatorActive, ioHold;
   stop_gating_pkg::module_power_t modulePower, expP;
   logic [11:0]                    awaddr, araddr;
   logic [31:0]                    wdata, rdata, cfgM, expS, d;
   logic [3:0]                     wstrb, s;
   logic [1:0]                     bresp, rresp;
   logic                           awvalid, awready, wvalid, wready, bvalid, bready;
   logic                           arvalid, arready, rvalid, rready;
   logic [33:0]                    expQ[$];
   logic [33:0]                    rExp;
   int                             failures = 0;
   int                             testsRun = 0;
   int                             cycles = 0;
   int                             i, b, n;
   localparam logic [33:0] RUN_POW  = {2'h0, 32'haaaaaaaa};
   localparam logic [33:0] RUN_STAT = {2'h0, 32'h00000139};
   localparam stop_gating_pkg::module_power_t ALL_ON = {17{2'h2}};

   always #2 sys_clk = ~sys_clk;

   cpu_stop_model cpu (.sys_clk(sys_clk), .reset(reset), .stopCmd(stopCmd),
      .wakeCmd(wakeCmd), .stopReq(stopReq), .wakeReq(wakeReq));

   stop_mode_peripheral_gating uut (.sys_clk(sys_clk), .reset(reset), .stopReq(stopReq),
      .wakeReq(wakeReq), .illegalStop(illegalStop), .periphClkEn(periphClkEn),
      .debugClkEn(debugClkEn), .regulatorActive(regulatorActive), .ioHold(ioHold),
      .modulePower(modulePower), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   function automatic stop_gating_pkg::module_power_t expPow(input stop_gating_pkg::cfg_t c);
      stop_gating_pkg::module_power_t p;
      logic                           det;
      det = c.lowVoltageDetectEnable & c.lowVoltageStopEnable;
      p = {17{2'h1}};
      if (c.partialPowerdownControl & !c.debugModeEnable & !det) begin
         p = '0;
         p.ram = stop_gating_pkg::PWR_STANDBY;
         p.usbRam = stop_gating_pkg::PWR_STANDBY;
      end else begin
         if (c.converterAsyncClockEnable & det) p.converter = stop_gating_pkg::PWR_ON;
         if (!c.comparatorBandgapSelect | det) p.analogComparator = stop_gating_pkg::PWR_ON;
         if (c.internalRefClockEnable & c.internalRefStopEnable) begin
            p.clockGenerator = stop_gating_pkg::PWR_ON;
         end
         if (c.externalRefClockEnable & c.externalRefStopEnable & (!c.oscHighRange | det)) begin
            p.externalOscillator = stop_gating_pkg::PWR_ON;
         end
         p.usb = stop_gating_pkg::PWR_OFF;
         if (c.usbModuleEnable & c.usbTransceiverEnable) p.usb = stop_gating_pkg::PWR_ON;
         if (c.debugModeEnable | det) p.regulator = stop_gating_pkg::PWR_ON;
      end
      p.counter = stop_gating_pkg::PWR_OFF;
      if (c.counterPrescalerSelect != `SG_PRESCALER_OFF) p.counter = stop_gating_pkg::PWR_ON;
      return p;
   endfunction : expPow

   function automatic logic [31:0] expStat(input stop_gating_pkg::cfg_t c,
                                           input logic [33:0] p);
      logic det, dbg, deep;
      det = c.lowVoltageDetectEnable & c.lowVoltageStopEnable;
      dbg = c.debugModeEnable;
      deep = c.partialPowerdownControl & !dbg & !det;
      return {23'h0, p[33:32], deep, !deep & (dbg | det), dbg, 1'b0, deep, !deep, 1'b0};
   endfunction : expStat

   task automatic axiWrite(input logic [11:0] a, input logic [31:0] dv,
                           input logic [3:0] sv, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= dv;
      wstrb <= sv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw || w) begin
         @(posedge sys_clk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
      // one idle edge so a following call never re-raises a strobe in the same step
      @(posedge sys_clk);
   endtask : axiWrite

   task automatic axiRead(input logic [11:0] a, input logic [33:0] e);
      expQ.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask : axiRead

   // read results are judged here against the oldest note
   always @(posedge sys_clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         rExp = expQ.pop_front();
         `CHK("rdata", rExp, {rresp, rdata})
      end
   end

   task final_report;
      $display("checks %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   // generous ceiling: the sequence needs well under two thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      void'($urandom(32'h5373c05a));
      {reset, stopCmd, wakeCmd, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      axiRead(`SG_CFG_OFFSET, 34'h0);
      axiRead(`SG_STATUS_OFFSET, RUN_STAT);
      axiRead(`SG_POWER_OFFSET, RUN_POW);
      axiRead(12'h00c, {`SG_RESP_SLVERR, 32'h0});
      axiWrite(12'h00c, 32'hffffffff, 4'hf, `SG_RESP_SLVERR);
      cfgM = '0;
      for (i = 0; i < 48; i++) begin
         d = $urandom;
         s = (i % 4 == 1) ? 4'($urandom) : 4'hf;
         d[0] = (i % 8 != 7);
         axiWrite(`SG_CFG_OFFSET, d, s, `SG_RESP_OKAY);
         for (b = 0; b < 4; b++) if (s[b]) cfgM[8*b+:8] = d[8*b+:8];
         cfgM = cfgM & `SG_CFG_WMASK;
         axiRead(`SG_CFG_OFFSET, {`SG_RESP_OKAY, cfgM});
         expP = expPow(cfgM);
         expS = expStat(cfgM, expP);
         stopCmd <= 1'b1;
         @(posedge sys_clk);
         stopCmd <= 1'b0;
         n = 0;
         repeat (4) begin
            @(posedge sys_clk);
            if (illegalStop !== 1'b0) n++;
         end
         `CHK("illegalStop", (cfgM[0] ? 0 : 1), n)
         `CHK("modulePower", (cfgM[0] ? expP : ALL_ON), modulePower)
         if (cfgM[0]) begin
            `CHK("periphClkEn", 1'b0, periphClkEn)
            `CHK("debugClkEn", expS[4], debugClkEn)
            `CHK("regulatorActive", expS[5], regulatorActive)
            `CHK("ioHold", expS[6], ioHold)
            // settings written mid-stop must not move the gating
            axiWrite(`SG_CFG_OFFSET, ~cfgM, 4'hf, `SG_RESP_OKAY);
            cfgM = ~cfgM & `SG_CFG_WMASK;
            axiRead(`SG_STATUS_OFFSET, {`SG_RESP_OKAY, expS});
            axiRead(`SG_POWER_OFFSET, {`SG_RESP_OKAY, expP[31:0]});
            wakeCmd <= 1'b1;
            @(posedge sys_clk);
            wakeCmd <= 1'b0;
            repeat (3) @(posedge sys_clk);
            `CHK("modulePower", ALL_ON, modulePower)
            axiRead(`SG_STATUS_OFFSET, RUN_STAT);
         end
      end
      final_report();
   end

endmodule : tb_top
